//--- hdl/bap_params.svh
`ifndef BAP_PARAMS_SVH
`define BAP_PARAMS_SVH

// Mode determination answers
`define BAP_ACK_UART 8'h86
`define BAP_ACK_SIO 8'h30

// Operation commands
`define BAP_CMD_RAM 8'h10
`define BAP_CMD_ERASE 8'h40

// Low nibble of command and checksum answers
`define BAP_NIB_OK 4'h0
`define BAP_NIB_BAD 4'h1
`define BAP_NIB_RXERR 4'h8

// Full answers on password area error
`define BAP_ACK_RAM_AREA 8'h11
`define BAP_ACK_ERASE_AREA 8'h41

// Erase progress answers
`define BAP_ACK_ERASE_GO 8'h54
`define BAP_ACK_ERASE_DONE 8'h4f
`define BAP_ACK_ERASE_FAIL 8'h4c

// Erased flash byte, no password needed
`define BAP_ERASED 8'hff

// Password area in flash, 16 bytes from the base
`define BAP_AREA_BASE 32'h3f81_fff0
`define BAP_AREA_HI_LSB 4
`define BAP_REQ_IDX 4'h0
`define BAP_PW_FIRST_IDX 4'h4
`define BAP_PW_LAST_IDX 4'hf

// Frame byte numbers
`define BAP_BYTE_PW_FIRST 5'd5
`define BAP_BYTE_PW_LAST 5'd16
`define BAP_BYTE_CK 5'd17

`endif

//--- hdl/bap_pkg.sv
package bap_pkg;

   typedef enum logic [2:0] {
      ST_SCAN,
      ST_MODE,
      ST_TX,
      ST_CMD,
      ST_DATA,
      ST_ERASE,
      ST_DONE,
      ST_ABORT
   } bap_state_type;

endpackage

//--- hdl/bap_pw_mem.sv
`timescale 1ns/100ps

module bap_pw_mem (
   // Clock
   input wire logic clk_sys,
   // Write port
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [7:0] wr_data,
   // Read port
   input wire logic [3:0] rd_idx,
   output logic [7:0] rd_data
);

   logic [7:0] mem [0:15];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      rd_data <= mem[rd_idx];
   end

endmodule

//--- hdl/bap_boot_ack.sv
// How it works
// [R1] Command and checksum answers carry the command byte's upper nibble.
// [R2] Answer bit 3 marks receive error, bit 0 command, checksum or password error.
// [R3] Answer bits 1 and 2 are always zero.
// [R4] In clocked serial mode receive errors are ignored.
// [R5] Mode answer is 0x86 for UART, 0x30 for clocked serial.
// [R6] UART with unusable baud rate aborts without any answer.
// [R7] Command echoed 0x10 or 0x40; undefined gives nibble 1, receive error nibble 8.
// [R8] Checksum answer nibble 0 correct, 1 checksum or password error, 8 receive error.
// [R9] Erase sends 0x54 on acceptance, 0x4F on completion, 0x4C on failure.
// [R10] Controller waits for flash ready, 200 us, then rechecks erase status; the code sends the erase answer on erase_done with no 200 us wait.
// [R11] Requirement byte at area base; 0xFF means no password needed.
// [R12] Stored password is the twelve bytes at offsets 4 to 15.
// [R13] RAM transfer always verifies the password.
// [R14] Erase verifies the password only when one is required.
// [R15] RAM transfer: identical non-0xFF password bytes give answer 0x11.
// [R16] Bytes 5 to 16 compared with stored password; mismatch fails checksum answer.
// [R17] Erase with password required and identical bytes gives answer 0x41.
// [R18] Verification runs regardless of security protection.
// [R19] Checksum is two's complement of the modulo 256 byte sum.
// [R20] Controller computes its checksum the same way.
// [R21] Controller opens with 0x86 for UART or 0x30 for clocked serial.
`timescale 1ns/100ps
`include "bap_params.svh"

module bap_boot_ack (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Mode determination result
   input wire logic mode_det_valid,
   input wire logic mode_det_uart,
   input wire logic mode_baud_ok,
   // Received bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_err,
   // Answer bytes
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   // Password area load
   input wire logic nvm_wr_en,
   input wire logic [31:0] nvm_wr_addr,
   input wire logic [7:0] nvm_wr_data,
   // Erase engine
   output logic erase_start,
   input wire logic erase_done,
   input wire logic erase_fail,
   // Status
   output logic ram_xfer_go,
   output logic io_mode,
   output logic aborted
);

   bap_pkg::bap_state_type st_q;
   bap_pkg::bap_state_type ret_q;
   logic tx_valid_q;
   logic [7:0] tx_data_q;
   logic pend_q;
   logic cmd_ack_q;
   logic erase_start_q;
   logic ram_xfer_go_q;
   logic io_mode_q;
   logic aborted_q;
   logic [7:0] cmd_q;
   logic [3:0] mem_addr_q;
   logic [3:0] lag_q;
   logic lag_vld_q;
   logic [7:0] req_q;
   logic [7:0] first_q;
   logic same_q;
   logic [4:0] byte_no_q;
   logic [7:0] sum_q;
   logic pw_bad_q;
   logic rxe_q;
   logic [7:0] rd_data;
   logic [4:0] byte_prev;
   logic is_ram;
   logic pw_req;
   logic verify;
   logic area_bad;
   logic rx_bad_now;
   logic [7:0] ck_sum;
   logic [3:0] ck_nib;
   logic ck_byte;
   logic nvm_hit;

   assign nvm_hit = nvm_wr_en && ((nvm_wr_addr >> `BAP_AREA_HI_LSB) == (`BAP_AREA_BASE >> `BAP_AREA_HI_LSB));

   bap_pw_mem u_mem (
      .clk_sys(clk_sys),
      .wr_en(nvm_hit),
      .wr_idx(nvm_wr_addr[3:0]),
      .wr_data(nvm_wr_data),
      .rd_idx(mem_addr_q),
      .rd_data(rd_data)
   );

   assign is_ram = (cmd_q == `BAP_CMD_RAM);
   assign pw_req = (req_q != `BAP_ERASED); // [R11]
   // Verification never looks at security protection [R18]
   assign verify = is_ram || pw_req; // [R13] [R14]
   assign area_bad = is_ram ? (same_q && (first_q != `BAP_ERASED)) : (pw_req && same_q); // [R15] [R17]
   assign rx_bad_now = rx_err && !io_mode_q; // [R4]
   assign ck_sum = sum_q + rx_data; // [R19]
   assign ck_byte = (byte_no_q == `BAP_BYTE_CK);
   assign byte_prev = byte_no_q - 5'd1;

   always_comb begin
      if (rxe_q || rx_bad_now) begin
         ck_nib = `BAP_NIB_RXERR; // [R8] [R2]
      end else if (area_bad || (verify && pw_bad_q) || (ck_sum != 8'h00)) begin
         ck_nib = `BAP_NIB_BAD; // [R8] [R16] [R19]
      end else begin
         ck_nib = `BAP_NIB_OK; // [R8]
      end
   end

   // Scan of the password area after reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mem_addr_q <= 4'h0;
         lag_q <= 4'h0;
         lag_vld_q <= 1'b0;
         req_q <= 8'hff;
         first_q <= 8'h00;
         same_q <= 1'b0;
      end else begin
         lag_q <= mem_addr_q;
         lag_vld_q <= (st_q == bap_pkg::ST_SCAN);
         if (st_q == bap_pkg::ST_SCAN) begin
            if (mem_addr_q != `BAP_PW_LAST_IDX) begin
               mem_addr_q <= mem_addr_q + 4'h1;
            end
         end else begin
            mem_addr_q <= byte_prev[3:0]; // [R12] [R16]
         end
         if ((st_q == bap_pkg::ST_SCAN) && lag_vld_q) begin
            if (lag_q == `BAP_REQ_IDX) begin
               req_q <= rd_data; // [R11]
            end
            if (lag_q == `BAP_PW_FIRST_IDX) begin
               first_q <= rd_data; // [R12]
               same_q <= 1'b1;
            end else if (lag_q > `BAP_PW_FIRST_IDX) begin
               same_q <= same_q && (rd_data == first_q); // [R15] [R17]
            end
         end
      end
   end

   // Frame sequencing and answer transmission
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= bap_pkg::ST_SCAN;
         ret_q <= bap_pkg::ST_CMD;
         tx_valid_q <= 1'b0;
         tx_data_q <= 8'h00;
         pend_q <= 1'b0;
         cmd_ack_q <= 1'b0;
         erase_start_q <= 1'b0;
         ram_xfer_go_q <= 1'b0;
         io_mode_q <= 1'b0;
         aborted_q <= 1'b0;
         cmd_q <= 8'h00;
      end else begin
         erase_start_q <= 1'b0;
         ram_xfer_go_q <= 1'b0;
         unique case (st_q)
            bap_pkg::ST_SCAN: begin
               if (lag_vld_q && (lag_q == `BAP_PW_LAST_IDX)) begin
                  st_q <= bap_pkg::ST_MODE;
               end
            end
            bap_pkg::ST_MODE: begin
               if (mode_det_valid) begin
                  if (mode_det_uart && !mode_baud_ok) begin
                     st_q <= bap_pkg::ST_ABORT; // [R6]
                     aborted_q <= 1'b1;
                  end else begin
                     io_mode_q <= !mode_det_uart;
                     tx_valid_q <= 1'b1;
                     tx_data_q <= mode_det_uart ? `BAP_ACK_UART : `BAP_ACK_SIO; // [R5]
                     cmd_ack_q <= 1'b0;
                     ret_q <= bap_pkg::ST_CMD;
                     st_q <= bap_pkg::ST_TX;
                  end
               end
            end
            bap_pkg::ST_TX: begin
               if (tx_ready) begin
                  if (pend_q) begin
                     pend_q <= 1'b0;
                     tx_data_q <= `BAP_ACK_ERASE_GO; // [R9]
                     cmd_ack_q <= 1'b0;
                     erase_start_q <= 1'b1;
                  end else begin
                     tx_valid_q <= 1'b0;
                     st_q <= ret_q;
                  end
               end
            end
            bap_pkg::ST_CMD: begin
               if (rx_valid) begin
                  cmd_q <= rx_data;
                  tx_valid_q <= 1'b1;
                  cmd_ack_q <= 1'b1;
                  st_q <= bap_pkg::ST_TX;
                  ret_q <= bap_pkg::ST_CMD;
                  if (rx_bad_now) begin
                     tx_data_q <= {rx_data[7:4], `BAP_NIB_RXERR}; // [R7] [R1] [R2]
                  end else if ((rx_data == `BAP_CMD_RAM) || (rx_data == `BAP_CMD_ERASE)) begin
                     tx_data_q <= rx_data; // [R7]
                     ret_q <= bap_pkg::ST_DATA;
                  end else begin
                     tx_data_q <= {rx_data[7:4], `BAP_NIB_BAD}; // [R7] [R1] [R2] [R3]
                  end
               end
            end
            bap_pkg::ST_DATA: begin
               if (rx_valid && ck_byte) begin
                  tx_valid_q <= 1'b1;
                  tx_data_q <= {cmd_q[7:4], ck_nib}; // [R1] [R3] [R8]
                  cmd_ack_q <= 1'b1;
                  st_q <= bap_pkg::ST_TX;
                  if (ck_nib != `BAP_NIB_OK) begin
                     ret_q <= bap_pkg::ST_CMD;
                  end else if (is_ram) begin
                     ret_q <= bap_pkg::ST_DONE;
                     ram_xfer_go_q <= 1'b1;
                  end else begin
                     ret_q <= bap_pkg::ST_ERASE;
                     pend_q <= 1'b1; // [R9]
                  end
               end
            end
            bap_pkg::ST_ERASE: begin
               if (erase_done) begin
                  tx_valid_q <= 1'b1;
                  tx_data_q <= erase_fail ? `BAP_ACK_ERASE_FAIL : `BAP_ACK_ERASE_DONE; // [R9]
                  cmd_ack_q <= 1'b0;
                  ret_q <= bap_pkg::ST_DONE;
                  st_q <= bap_pkg::ST_TX;
               end
            end
            bap_pkg::ST_DONE: begin
               st_q <= bap_pkg::ST_DONE;
            end
            bap_pkg::ST_ABORT: begin
               st_q <= bap_pkg::ST_ABORT;
            end
         endcase
      end
   end

   // Password compare, checksum sum and receive error tracking
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         byte_no_q <= `BAP_BYTE_PW_FIRST;
         sum_q <= 8'h00;
         pw_bad_q <= 1'b0;
         rxe_q <= 1'b0;
      end else if (st_q == bap_pkg::ST_CMD) begin
         byte_no_q <= `BAP_BYTE_PW_FIRST;
         sum_q <= 8'h00;
         pw_bad_q <= 1'b0;
         rxe_q <= 1'b0;
      end else if ((st_q == bap_pkg::ST_DATA) && rx_valid && !ck_byte) begin
         byte_no_q <= byte_no_q + 5'd1;
         sum_q <= ck_sum; // [R19]
         if (rx_bad_now) begin
            rxe_q <= 1'b1; // [R4]
         end
         if ((byte_no_q >= `BAP_BYTE_PW_FIRST) && (byte_no_q <= `BAP_BYTE_PW_LAST) && (rx_data != rd_data)) begin
            pw_bad_q <= 1'b1; // [R16]
         end
      end
   end

   assign tx_valid = tx_valid_q;
   assign tx_data = tx_data_q;
   assign erase_start = erase_start_q;
   assign ram_xfer_go = ram_xfer_go_q;
   assign io_mode = io_mode_q;
   assign aborted = aborted_q;

   property p_hi_nibble;
      @(posedge clk_sys) disable iff (rst)
      (tx_valid_q && cmd_ack_q) |-> (tx_data_q[7:4] == cmd_q[7:4]);
   endproperty
   a_hi_nibble: assert property (p_hi_nibble) // [R1]
      else $error("answer upper nibble differs from command");

   property p_zero_bits;
      @(posedge clk_sys) disable iff (rst)
      (tx_valid_q && cmd_ack_q) |-> (tx_data_q[2:1] == 2'b00);
   endproperty
   a_zero_bits: assert property (p_zero_bits) // [R3]
      else $error("answer bits 2:1 not zero");

   property p_sio_no_rxerr;
      @(posedge clk_sys) disable iff (rst)
      (tx_valid_q && cmd_ack_q && io_mode_q) |-> !tx_data_q[3];
   endproperty
   a_sio_no_rxerr: assert property (p_sio_no_rxerr) // [R4]
      else $error("receive error flagged in clocked serial mode");

   property p_mode_ack;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_MODE) && mode_det_valid && !(mode_det_uart && !mode_baud_ok))
      |=> (tx_valid_q && (tx_data_q == ($past(mode_det_uart) ? `BAP_ACK_UART : `BAP_ACK_SIO)));
   endproperty
   a_mode_ack: assert property (p_mode_ack) // [R5]
      else $error("wrong mode answer");

   property p_abort_silent;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_MODE) && mode_det_valid && mode_det_uart && !mode_baud_ok) |=> (!tx_valid_q)[*8];
   endproperty
   a_abort_silent: assert property (p_abort_silent) // [R6]
      else $error("answer sent after baud rate failure");

   property p_ram_echo;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_CMD) && rx_valid && !rx_bad_now && (rx_data == `BAP_CMD_RAM))
      |=> (tx_valid_q && (tx_data_q == `BAP_CMD_RAM) && (st_q == bap_pkg::ST_TX));
   endproperty
   a_ram_echo: assert property (p_ram_echo) // [R7]
      else $error("RAM transfer command not echoed");

   property p_rxerr_nib;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_DATA) && rx_valid && ck_byte && rxe_q) |=> (tx_data_q[3:0] == `BAP_NIB_RXERR);
   endproperty
   a_rxerr_nib: assert property (p_rxerr_nib) // [R2]
      else $error("receive error not reported in checksum answer");

   property p_sum_bad;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_DATA) && rx_valid && ck_byte && (ck_sum != 8'h00)) |=> (tx_data_q[3:0] != `BAP_NIB_OK);
   endproperty
   a_sum_bad: assert property (p_sum_bad) // [R19]
      else $error("bad checksum answered as correct");

   property p_pw_bad;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_DATA) && rx_valid && ck_byte && verify && pw_bad_q) |=> (tx_data_q[3:0] != `BAP_NIB_OK);
   endproperty
   a_pw_bad: assert property (p_pw_bad) // [R16]
      else $error("password mismatch answered as correct");

   property p_ram_area;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_DATA) && rx_valid && ck_byte && is_ram && area_bad && !rxe_q && !rx_bad_now)
      |=> (tx_data_q == `BAP_ACK_RAM_AREA);
   endproperty
   a_ram_area: assert property (p_ram_area) // [R15]
      else $error("password area error not answered 0x11");

   property p_erase_area;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_DATA) && rx_valid && ck_byte && !is_ram && pw_req && same_q && !rxe_q && !rx_bad_now)
      |=> (tx_data_q == `BAP_ACK_ERASE_AREA);
   endproperty
   a_erase_area: assert property (p_erase_area) // [R17]
      else $error("erase password area error not answered 0x41");

   property p_erase_done;
      @(posedge clk_sys) disable iff (rst)
      ((st_q == bap_pkg::ST_ERASE) && erase_done)
      |=> (tx_valid_q && (tx_data_q == ($past(erase_fail) ? `BAP_ACK_ERASE_FAIL : `BAP_ACK_ERASE_DONE)));
   endproperty
   a_erase_done: assert property (p_erase_done) // [R9]
      else $error("wrong erase result answer");

endmodule

//--- verif/bap_ctl_model.sv
`timescale 1ns/100ps

module bap_ctl_model (
   // Clock
   input wire logic clk_sys,
   // Pacing of the controller
   input wire logic slow,
   // Answer handshake
   input wire logic tx_valid,
   output logic tx_ready
);
   // Prompt taker, or random stalls while an answer waits
   always @(negedge clk_sys) begin
      if (slow)
         tx_ready <= tx_valid && ($urandom_range(2, 0) == 0);
      else
         tx_ready <= 1'b1;
   end
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
`include "bap_params.svh"

module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic mode_det_valid = 1'b0;
   logic mode_det_uart = 1'b0;
   logic mode_baud_ok = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic rx_err = 1'b0;
   logic tx_valid;
   logic [7:0] tx_data;
   logic tx_ready;
   logic nvm_wr_en = 1'b0;
   logic [31:0] nvm_wr_addr = 32'h0000_0000;
   logic [7:0] nvm_wr_data = 8'h00;
   logic erase_start;
   logic erase_done = 1'b0;
   logic erase_fail = 1'b0;
   logic ram_xfer_go;
   logic io_mode;
   logic aborted;
   logic slow = 1'b0;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int n_compared = 0;
   int n_go = 0;
   int n_ers = 0;
   int cyc = 0;

   always #25 clk_sys = ~clk_sys;

   bap_boot_ack i_dut (.clk_sys(clk_sys), .rst(rst), .mode_det_valid(mode_det_valid),
      .mode_det_uart(mode_det_uart), .mode_baud_ok(mode_baud_ok), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .nvm_wr_en(nvm_wr_en),
      .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .erase_start(erase_start),
      .erase_done(erase_done), .erase_fail(erase_fail), .ram_xfer_go(ram_xfer_go), .io_mode(io_mode),
      .aborted(aborted));

   bap_ctl_model i_ctl (.clk_sys(clk_sys), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready));

   task automatic stop_test();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Every answer taken is matched with the oldest expectation
   always @(posedge clk_sys) begin
      cyc++;
      if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0)
            check("unexpected answer", 32'h100, {24'h0, tx_data});
         else
            check("answer", {24'h0, exp_q.pop_front()}, {24'h0, tx_data});
      end
      if (ram_xfer_go === 1'b1)
         n_go++;
      if (erase_start === 1'b1)
         n_ers++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   function automatic logic [7:0] csum(input logic [7:0] pw [12]);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 12; i++)
         s = s + pw[i];
      return 8'h00 - s;
   endfunction

   task automatic wait_idle();
      int k;
      k = 0;
      while ((exp_q.size() != 0 || tx_valid !== 1'b0) && k < 300) begin
         @(negedge clk_sys);
         k++;
      end
      if (k == 300)
         check("idle wait", 32'h0, 32'h1);
   endtask

   // Password store is loaded while reset holds
   task automatic boot(input logic [7:0] req, input logic [7:0] pw [12]);
      rst = 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk_sys);
         nvm_wr_en = 1'b1;
         nvm_wr_addr = `BAP_AREA_BASE + 32'(i);
         nvm_wr_data = (i == 0) ? req : (i < 4) ? 8'h00 : pw[i-4];
      end
      @(negedge clk_sys);
      nvm_wr_en = 1'b0;
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (20) @(negedge clk_sys);
   endtask

   task automatic mode(input logic uart, input logic baud_ok);
      mode_det_valid = 1'b1;
      mode_det_uart = uart;
      mode_baud_ok = baud_ok;
      if (!uart || baud_ok)
         exp_q.push_back(uart ? `BAP_ACK_UART : `BAP_ACK_SIO);
      @(negedge clk_sys);
      mode_det_valid = 1'b0;
      wait_idle();
   endtask

   task automatic send(input logic [7:0] b, input logic err);
      repeat (3) @(negedge clk_sys);
      rx_data = b;
      rx_err = err;
      rx_valid = 1'b1;
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_err = 1'b0;
      rx_data = ~b;
   endtask

   task automatic cmd(input logic [7:0] b, input logic err, input logic [7:0] exp);
      wait_idle();
      send(b, err);
      exp_q.push_back(exp);
   endtask

   task automatic frame(input logic [7:0] pw [12], input logic [7:0] cs, input int err_at, input logic [7:0] exp);
      wait_idle();
      for (int i = 0; i < 12; i++)
         send(pw[i], i == err_at);
      send(cs, err_at == 12);
      exp_q.push_back(exp);
      if (exp == `BAP_CMD_ERASE)
         exp_q.push_back(`BAP_ACK_ERASE_GO);
      wait_idle();
   endtask

   // Progress is rechecked only once the engine reports its end
   task automatic end_erase(input logic fail, input logic [7:0] exp);
      wait_idle();
      exp_q.push_back(exp);
      erase_done = 1'b1;
      erase_fail = fail;
      @(negedge clk_sys);
      erase_done = 1'b0;
      erase_fail = ~fail;
      wait_idle();
   endtask

   initial begin
      logic [7:0] pw [12];
      logic [7:0] bad [12];
      logic [7:0] same [12];
      void'($urandom(93));
      for (int i = 0; i < 12; i++) begin
         pw[i] = 8'($urandom);
         same[i] = 8'h5a;
      end
      pw[1] = pw[0] ^ 8'h5a;
      bad = pw;
      bad[11] = pw[11] ^ 8'h01;
      repeat (8) @(negedge clk_sys);
      // UART session, no password requirement
      boot(8'hff, pw);
      mode(1'b1, 1'b1);
      cmd(8'h25, 1'b0, 8'h21);
      cmd(8'h73, 1'b1, 8'h78);
      cmd(8'h10, 1'b0, 8'h10);
      frame(pw, csum(pw) + 8'h01, -1, 8'h11);
      cmd(8'h10, 1'b0, 8'h10);
      frame(bad, csum(bad), -1, 8'h11);
      cmd(8'h10, 1'b0, 8'h10);
      frame(pw, csum(pw), 5, 8'h18);
      cmd(8'h10, 1'b0, 8'h10);
      frame(pw, csum(pw), -1, 8'h10);
      check("transfer start count", 32'd1, 32'(n_go));
      // Clocked serial session with a slow controller
      boot(8'hff, pw);
      slow = 1'b1;
      mode(1'b0, 1'b1);
      check("clocked mode flag", 32'h1, {31'h0, io_mode});
      cmd(8'h40, 1'b1, 8'h40);
      frame(bad, csum(bad), 3, 8'h40);
      check("erase start count", 32'd1, 32'(n_ers));
      end_erase(1'b0, `BAP_ACK_ERASE_DONE);
      slow = 1'b0;
      // Password required, all stored bytes identical
      boot(8'h00, same);
      mode(1'b1, 1'b1);
      cmd(8'h10, 1'b0, 8'h10);
      frame(same, csum(same), -1, `BAP_ACK_RAM_AREA);
      cmd(8'h40, 1'b0, 8'h40);
      frame(same, csum(same), -1, `BAP_ACK_ERASE_AREA);
      // Password required, distinct stored bytes
      boot(8'h3c, pw);
      mode(1'b1, 1'b1);
      cmd(8'h40, 1'b0, 8'h40);
      frame(bad, csum(bad), -1, 8'h41);
      cmd(8'h40, 1'b0, 8'h40);
      frame(pw, csum(pw), -1, 8'h40);
      end_erase(1'b1, `BAP_ACK_ERASE_FAIL);
      check("erase start count", 32'd2, 32'(n_ers));
      // UART with unusable baud rate stays silent
      boot(8'hff, pw);
      mode(1'b1, 1'b0);
      check("abort flag", 32'h1, {31'h0, aborted});
      send(8'h10, 1'b0);
      repeat (20) @(negedge clk_sys);
      check("silent after abort", 32'h0, {31'h0, tx_valid});
      stop_test();
   end
endmodule
